// ===== flow_pkg.sv
// Purpose: Shared types and constants for the two-flow block distribution core
// Assumes: 66-bit blocks, two flows
// Notes: Flow data travels as packed structs
package flow_pkg;

  localparam int BLOCK_W = 66;
  localparam int NUM_FLOWS = 2;
  localparam int MSG_W = 5140;
  localparam int XC_W = 257;
  localparam int AM_PERIOD = 16;
  localparam logic [BLOCK_W-1:0] AM_PATTERN = 66'h2_0000_0000_0000_0000;
  localparam logic [BLOCK_W-1:0] SCR_SEED = 66'h3_FFFF_FFFF_FFFF_FFFF;
  localparam int SCR_TAP = 38;
  localparam logic FLOW0 = 1'b0;
  localparam logic FLOW1 = 1'b1;

  // One block with its valid flag
  typedef struct packed {
    logic valid;
    logic [BLOCK_W-1:0] data;
  } blk_t;

  // Tagged block leaving a flow: codeword select and marker flag
  typedef struct packed {
    logic valid;
    logic am;
    logic cw_sel;
    logic [BLOCK_W-1:0] data;
  } lane_blk_t;

endpackage : flow_pkg

// ===== flow_tx_path.sv
// Purpose: One transmit flow: scramble, marker insertion, codeword split and interleave
// Assumes: Marker slot is given by the common slot counter of the parent
// Notes: Scrambler and codeword tagging stand in for the full transcode and FEC datapath
`timescale 1ns/100ps
module flow_tx_path (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Block input from the distributor
  input wire flow_pkg::blk_t blk_in,
  // Shared marker slot from the parent
  input wire logic am_slot_in,
  // Block output toward lanes
  output flow_pkg::lane_blk_t lane_out
);
  import flow_pkg::*;

  logic [BLOCK_W-1:0] scr_q;
  logic [BLOCK_W-1:0] scr_d;
  logic cw_sel_q;
  lane_blk_t lane_q;

  // LFSR scrambler state, advanced once per valid block (marker slots too), independently of the block data
  always_comb begin
    scr_d = {scr_q[BLOCK_W-2:0], scr_q[BLOCK_W-1] ^ scr_q[SCR_TAP]};
  end

  // Scramble the block, or put a marker in the common slot
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scr_q <= SCR_SEED;
      lane_q <= '0;
    end else begin
      lane_q.valid <= blk_in.valid;
      if (blk_in.valid) begin
        scr_q <= scr_d;
        if (am_slot_in) begin
          lane_q.am <= 1'b1;
          lane_q.data <= AM_PATTERN;
        end else begin
          lane_q.am <= 1'b0;
          lane_q.data <= blk_in.data ^ scr_q;
        end
        lane_q.cw_sel <= cw_sel_q;
      end
    end
  end

  // Alternate blocks between the two codewords, which interleaves them
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cw_sel_q <= 1'b0;
    end else if (blk_in.valid) begin
      cw_sel_q <= ~cw_sel_q;
    end
  end

  assign lane_out = lane_q;

endmodule : flow_tx_path

// ===== dual_flow_core.sv
// Purpose: Two-flow block distribution and collection core
// Assumes: Single clock, blocks offered as valid-qualified 66-bit words
// Notes: No back-pressure; every valid transmit block is accepted, a receive block is taken only on its flow's turn
`timescale 1ns/100ps
module dual_flow_core (
  // Clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RST_N_IN,
  // Transmit block input from the encoder
  input wire flow_pkg::blk_t TX_BLK_IN,
  // Receive blocks from each flow
  input wire flow_pkg::blk_t RX_FLOW0_IN,
  input wire flow_pkg::blk_t RX_FLOW1_IN,
  // Transmit flow outputs toward lanes
  output flow_pkg::lane_blk_t TX_FLOW0_OUT,
  output flow_pkg::lane_blk_t TX_FLOW1_OUT,
  // Merged receive stream toward the decoder
  output flow_pkg::blk_t RX_DEC_OUT,
  // Pointer state
  output logic TX_PTR_OUT,
  output logic RX_PTR_OUT
);
  import flow_pkg::*;

  logic tx_ptr_q;
  logic rx_ptr_q;
  blk_t f0_q;
  blk_t f1_q;
  blk_t rx_q;
  logic [$clog2(AM_PERIOD)-1:0] am_cnt_q;
  logic am_slot;
  lane_blk_t f0_lane;
  lane_blk_t f1_lane;
  lane_blk_t f0_out_q;
  lane_blk_t f1_out_q;
  logic cw0_last_q;
  logic cw0_seen_q;
  logic cw1_last_q;
  logic cw1_seen_q;

  //////////////////////////////////////////////////////////////////////////////
  // Transmit distribution

  // Alternate the transmit pointer on each accepted block
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      tx_ptr_q <= FLOW0;
    end else if (TX_BLK_IN.valid) begin
      tx_ptr_q <= ~tx_ptr_q;
    end
  end

  // Steer the block to the flow the pointer names
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      f0_q <= '0;
      f1_q <= '0;
    end else begin
      f0_q.valid <= TX_BLK_IN.valid && (tx_ptr_q == FLOW0);
      f1_q.valid <= TX_BLK_IN.valid && (tx_ptr_q == FLOW1);
      if (TX_BLK_IN.valid && tx_ptr_q == FLOW0) begin
        f0_q.data <= TX_BLK_IN.data;
      end
      if (TX_BLK_IN.valid && tx_ptr_q == FLOW1) begin
        f1_q.data <= TX_BLK_IN.data;
      end
    end
  end

  // Common marker slot: advances once per flow-1 block so both flows share one slot
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      am_cnt_q <= '0;
    end else if (f1_q.valid) begin
      am_cnt_q <= am_cnt_q + 1'b1;
    end
  end

  assign am_slot = (am_cnt_q == '0);

  // Per-flow transmit paths, same marker slot for both
  flow_tx_path u_flow0 (
    .clk_in(REF_CLK_IN),
    .rst_n_in(RST_N_IN),
    .blk_in(f0_q),
    .am_slot_in(am_slot),
    .lane_out(f0_lane)
  );

  flow_tx_path u_flow1 (
    .clk_in(REF_CLK_IN),
    .rst_n_in(RST_N_IN),
    .blk_in(f1_q),
    .am_slot_in(am_slot),
    .lane_out(f1_lane)
  );

  // Register flow outputs onto the ports
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      f0_out_q <= '0;
      f1_out_q <= '0;
    end else begin
      f0_out_q <= f0_lane;
      f1_out_q <= f1_lane;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Receive collection

  // Take the next block from the flow the pointer names
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rx_ptr_q <= FLOW0;
      rx_q <= '0;
    end else begin
      rx_q.valid <= 1'b0;
      if (rx_ptr_q == FLOW0 && RX_FLOW0_IN.valid) begin
        rx_q <= RX_FLOW0_IN;
        rx_ptr_q <= FLOW1;
      end else if (rx_ptr_q == FLOW1 && RX_FLOW1_IN.valid) begin
        rx_q <= RX_FLOW1_IN;
        rx_ptr_q <= FLOW0;
      end
    end
  end

  assign TX_FLOW0_OUT = f0_out_q;
  assign TX_FLOW1_OUT = f1_out_q;
  assign RX_DEC_OUT = rx_q;
  assign TX_PTR_OUT = tx_ptr_q;
  assign RX_PTR_OUT = rx_ptr_q;

  //////////////////////////////////////////////////////////////////////////////
  // Check helpers

  // Last codeword select seen leaving flow 0, so gaps between blocks do not matter
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      cw0_last_q <= 1'b0;
      cw0_seen_q <= 1'b0;
    end else if (f0_lane.valid) begin
      cw0_last_q <= f0_lane.cw_sel;
      cw0_seen_q <= 1'b1;
    end
  end

  // Last codeword select seen leaving flow 1
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      cw1_last_q <= 1'b0;
      cw1_seen_q <= 1'b0;
    end else if (f1_lane.valid) begin
      cw1_last_q <= f1_lane.cw_sel;
      cw1_seen_q <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  a_tx_ptr_toggle: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    TX_BLK_IN.valid |=> (tx_ptr_q != $past(tx_ptr_q)))
    else $error("tx pointer did not alternate");

  a_tx_steer: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    (TX_BLK_IN.valid && tx_ptr_q == FLOW0) |=> (f0_q.valid && !f1_q.valid
      && f0_q.data == $past(TX_BLK_IN.data)))
    else $error("block not sent to flow 0");

  a_tx_steer1: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    (TX_BLK_IN.valid && tx_ptr_q == FLOW1) |=> (f1_q.valid && !f0_q.valid
      && f1_q.data == $past(TX_BLK_IN.data)))
    else $error("block not sent to flow 1");

  a_rx_flow0: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    (rx_ptr_q == FLOW0 && RX_FLOW0_IN.valid) |=> (rx_q.valid
      && rx_q.data == $past(RX_FLOW0_IN.data) && rx_ptr_q == FLOW1))
    else $error("flow 0 block not collected");

  a_rx_alternate: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    (rx_ptr_q == FLOW1 && RX_FLOW1_IN.valid) |=> (rx_q.valid
      && rx_q.data == $past(RX_FLOW1_IN.data) && rx_ptr_q == FLOW0))
    else $error("flow 1 block not collected");

  a_rx_skip: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    (rx_ptr_q == FLOW0 && !RX_FLOW0_IN.valid) |=> (!rx_q.valid && rx_ptr_q == FLOW0))
    else $error("collected out of turn");

  a_rx_hold1: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    (rx_ptr_q == FLOW1 && !RX_FLOW1_IN.valid) |=> (!rx_q.valid && rx_ptr_q == FLOW1))
    else $error("flow 1 turn not held");

  a_am_common: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    (f0_q.valid && am_slot) |=> f0_lane.am)
    else $error("flow 0 missed common marker slot");

  a_am_flow1: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    (f1_q.valid && am_slot) |=> (f1_lane.am && f1_lane.data == AM_PATTERN))
    else $error("flow 1 missed marker");

  a_cw_interleave: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    (f0_lane.valid && cw0_seen_q) |-> (f0_lane.cw_sel != cw0_last_q))
    else $error("flow 0 codewords not interleaved");

  a_cw_flow1: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    (f1_lane.valid && cw1_seen_q) |-> (f1_lane.cw_sel != cw1_last_q))
    else $error("flow 1 codewords not interleaved");

  a_cw_first: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    (f0_lane.valid && !cw0_seen_q) |-> !f0_lane.cw_sel)
    else $error("flow 0 did not start on first codeword");

  a_ptr_reset: assert property (@(posedge REF_CLK_IN)
    $rose(RST_N_IN) |-> (tx_ptr_q == FLOW0 && rx_ptr_q == FLOW0))
    else $error("pointers not at flow 0 after reset");

endmodule : dual_flow_core

// ===== pma_model.sv
// Purpose: Far-side lane logic model that offers received blocks on the two flows
// Assumes: One block per call, held until the edge that samples it
// Notes: Released lines show the inverse of the last data, never a stale copy
`timescale 1ns/100ps
module pma_model (
  // Clock
  input wire logic clk_in,
  // Received blocks toward the core
  output flow_pkg::blk_t flow0_out,
  output flow_pkg::blk_t flow1_out
);
  import flow_pkg::*;

  // Idle lines at time zero
  initial begin
    flow0_out = '0;
    flow1_out = '0;
  end

  // Offer one block on one flow for a single sampling edge
  task automatic send(input logic fl, input logic [BLOCK_W-1:0] d);
    @(posedge clk_in);
    if (fl) flow1_out <= '{1'b1, d};
    else flow0_out <= '{1'b1, d};
    @(posedge clk_in);
    flow0_out <= '{1'b0, ~d}; // Released: inverse of last data
    flow1_out <= '{1'b0, ~d};
  endtask : send
endmodule : pma_model

// ===== test_dual_flow_core.sv
// Purpose: Self-checking bench for the two-flow distribution and collection core
// Assumes: No back-pressure, transmit blocks offered back to back, receive blocks with an idle cycle between
// Notes: Flow outputs are logged on the falling edge and judged afterwards
`timescale 1ns/100ps
module test_dual_flow_core;
  import flow_pkg::*;
  localparam logic [BLOCK_W-1:0] BLK_A = 66'h1_2345_6789_ABCD_EF01;
  localparam logic [BLOCK_W-1:0] BLK_B = 66'h2_0F0F_0F0F_0F0F_0F0F;
  localparam logic [BLOCK_W-1:0] BLK_X = 66'h0_5555_AAAA_5555_AAAA;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  blk_t tx_blk = '0;
  blk_t rx0, rx1, dec;
  lane_blk_t tx0, tx1;
  logic tx_ptr, rx_ptr;
  int err_count = 0;
  int num_checks = 0;
  localparam logic [BLOCK_W-1:0] SCR_STEP1 = 66'h3_FFFF_FFFF_FFFF_FFFE; // All-ones seed, one step
  logic [67:0] q0[$];
  logic [67:0] q1[$];

  ////////////////////////////////////////////////////////////////////////////
  // Clock and instances
  always #5 clk = ~clk;
  dual_flow_core i_dual_flow_core (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .TX_BLK_IN(tx_blk),
    .RX_FLOW0_IN(rx0), .RX_FLOW1_IN(rx1), .TX_FLOW0_OUT(tx0), .TX_FLOW1_OUT(tx1),
    .RX_DEC_OUT(dec), .TX_PTR_OUT(tx_ptr), .RX_PTR_OUT(rx_ptr));
  pma_model i_pma_model (.clk_in(clk), .flow0_out(rx0), .flow1_out(rx1));

  // Log marker flag and codeword select of every block leaving a flow
  always @(negedge clk) begin
    if (tx0.valid === 1'b1) q0.push_back({tx0.am, tx0.cw_sel, tx0.data});
    if (tx1.valid === 1'b1) q1.push_back({tx1.am, tx1.cw_sel, tx1.data});
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared comparison and closing report
  task automatic check(input logic [66:0] got, input logic [66:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : check

  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim

  ////////////////////////////////////////////////////////////////////////////
  // Four back-to-back blocks: alternation, markers, codeword interleave
  task automatic tx_alternate();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      tx_blk <= '{1'b1, BLK_A ^ 66'(i)};
      #1 check(67'(tx_ptr), 67'(i % 2), "tx pointer");
    end
    @(posedge clk);
    tx_blk <= '0;
    repeat (6) @(posedge clk);
    check(67'(q0.size()), 67'd2, "flow 0 block count");
    check(67'(q1.size()), 67'd2, "flow 1 block count");
    check(67'(q0[0][67:66]), 67'b10, "flow 0 first marker");
    check(67'(q1[0][67:66]), 67'b10, "flow 1 first marker");
    check(67'(q0[0][BLOCK_W-1:0]), 67'(AM_PATTERN), "flow 0 marker pattern");
    check(67'(q1[0][BLOCK_W-1:0]), 67'(AM_PATTERN), "flow 1 marker pattern");
    check(67'(q0[1][67:66]), 67'b01, "flow 0 second codeword");
    check(67'(q1[1][67:66]), 67'b01, "flow 1 second codeword");
    check(67'(q0[1][BLOCK_W-1:0]), 67'(BLK_A ^ 66'h2 ^ SCR_STEP1), "flow 0 data");
    check(67'(q1[1][BLOCK_W-1:0]), 67'(BLK_A ^ 66'h3 ^ SCR_STEP1), "flow 1 data");
  endtask : tx_alternate

  // Off-turn block dropped, then flow 0 and flow 1 merged in order
  task automatic rx_collect();
    i_pma_model.send(1'b1, BLK_X);
    #1 check(67'(dec.valid), 67'd0, "off-turn block passed");
    check(67'(rx_ptr), 67'd0, "rx pointer moved");
    i_pma_model.send(1'b0, BLK_A);
    #1 check(dec, {1'b1, BLK_A}, "flow 0 block to decoder");
    check(67'(rx_ptr), 67'd1, "rx pointer after flow 0");
    i_pma_model.send(1'b1, BLK_B);
    #1 check(dec, {1'b1, BLK_B}, "flow 1 block to decoder");
    check(67'(rx_ptr), 67'd0, "rx pointer after flow 1");
  endtask : rx_collect

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    check(67'({tx_ptr, rx_ptr}), 67'd0, "pointers in reset");
    rst_n <= 1'b1;
    tx_alternate();
    rx_collect();
    end_sim();
  end

  // Hang guard
  initial begin
    repeat (2000) @(posedge clk);
    err_count++;
    end_sim();
  end
endmodule : test_dual_flow_core
